// ==== design/udc_top.sv ====
// up/down selectable 32-bit counter with preset, zero flag and comparators
// assumes ladder inputs arrive asynchronously, registers over axi4-lite
//
// Overview of operation
// - preset is any unsigned 32-bit value, constant or from storage
// - stored preset joins two 16-bit data words, high word and low word
// - pulses are ignored while preset input is on
// - counting of rising pulse edges resumes one scan after preset falls
// - controller raises preset first; while on, current loads preset
// - count up when direction input high, down when low
// - zero output on exactly when current value is zero
// - down count from zero wraps to all ones
// - up count from all ones wraps to zero
// - current value survives reset unless clear-at-power-up is chosen
// - software writes of preset or current take effect at once
// - counter owns two slots, base slot at most 254
// - software preset change touches only the working copy
// - confirm copies working preset into the non-volatile copy
// - clear reloads working preset from the non-volatile copy
// - equal result on while selected current equals compare value
// - at-least result on while selected current is at least compare value
// - comparator selects counter 0..255, compare value 16 bits
// - stored compare value is a single 16-bit word
// - comparators look only at the current value
// - compare result starts a term, then and/or with a condition
//
// The AXI4-Lite slave port and the register offsets were decided locally.
`timescale 1ns/1ns
module udc_top
  import udc_pkg::*;
#(
  parameter int unsigned SCAN_DIV = SCAN_CYCLES,
  parameter logic [7:0] BASE_SLOT = 8'h04,
  parameter bit CLEAR_ON_POWERUP = 1'b0
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // ladder conditions
  input wire udc_ladder_t ladder_in,
  // results
  output logic counter_zero,
  output logic equal_out,
  output logic at_least_out,
  output logic term_out
);

  // ****************************************************************
  // elaboration checks
  // ****************************************************************
  if (SCAN_DIV < 2) begin : g_bad_div
    $error("scan divider must be at least 2");
  end
  if (BASE_SLOT > MAX_BASE_SLOT) begin : g_bad_slot
    $error("base slot must leave room for the second slot");
  end

  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] dat,
                                         input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = dat[8*i +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic addr_mapped(input logic [7:0] a);
    return a == OFS_CTRL || a == OFS_PRESET || a == OFS_DATA_LO ||
           a == OFS_DATA_HI || a == OFS_CURRENT || a == OFS_NV_PRESET ||
           a == OFS_CMD || a == OFS_CMP_CONST || a == OFS_CMP_WORD ||
           a == OFS_STATUS;
  endfunction

  // ****************************************************************
  // input synchroniser and scan divider
  // ****************************************************************
  udc_ladder_t sync1_q, sync2_q, last_q, last_d;
  logic [$clog2(SCAN_DIV)-1:0] div_q, div_d;
  logic scan_q, scan_d;

  always_comb begin
    div_d = div_q + 1'b1;
    scan_d = 1'b0;
    last_d = last_q;
    if (div_q == ($clog2(SCAN_DIV))'(SCAN_DIV - 1)) begin
      div_d = '0;
      scan_d = 1'b1;
    end
    if (scan_q) begin
      last_d = sync2_q;
    end
  end

  always_ff @(posedge aclk) begin
    sync1_q <= ladder_in;
    sync2_q <= sync1_q;
    if (!aresetn) begin
      div_q <= '0;
      scan_q <= 1'b0;
      // take the present level so a held pulse is no edge after reset
      last_q <= sync2_q;
    end else begin
      div_q <= div_d;
      scan_q <= scan_d;
      last_q <= last_d;
    end
  end

  // ****************************************************************
  // axi4-lite slave
  // ****************************************************************
  logic aw_full_q, aw_full_d, w_full_q, w_full_d;
  logic [7:0] waddr_q, waddr_d;
  logic [31:0] wdat_q, wdat_d;
  logic [3:0] wstb_q, wstb_d;
  logic awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
  logic [1:0] bresp_d, rresp_d;
  logic [31:0] rdata_d, rd_mux;
  logic do_write;

  assign do_write = aw_full_q && w_full_q && !bvalid;

  always_comb begin
    aw_full_d = aw_full_q;
    w_full_d = w_full_q;
    waddr_d = waddr_q;
    wdat_d = wdat_q;
    wstb_d = wstb_q;
    bvalid_d = bvalid;
    bresp_d = bresp;
    if (awvalid && awready) begin
      aw_full_d = 1'b1;
      waddr_d = awaddr;
    end
    if (wvalid && wready) begin
      w_full_d = 1'b1;
      wdat_d = wdata;
      wstb_d = wstrb;
    end
    if (bvalid && bready) begin
      bvalid_d = 1'b0;
    end
    if (do_write) begin
      aw_full_d = 1'b0;
      w_full_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = addr_mapped(waddr_q) ? RESP_OKAY : RESP_SLVERR;
    end
    awready_d = !aw_full_d;
    wready_d = !w_full_d;
  end

  always_comb begin
    rvalid_d = rvalid;
    rdata_d = rdata;
    rresp_d = rresp;
    if (rvalid && rready) begin
      rvalid_d = 1'b0;
    end
    if (arvalid && arready) begin
      rvalid_d = 1'b1;
      rdata_d = rd_mux;
      rresp_d = addr_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    arready_d = !rvalid_d;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      waddr_q <= '0;
      wdat_q <= '0;
      wstb_q <= '0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else begin
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      waddr_q <= waddr_d;
      wdat_q <= wdat_d;
      wstb_q <= wstb_d;
      awready <= awready_d;
      wready <= wready_d;
      bvalid <= bvalid_d;
      bresp <= bresp_d;
      arready <= arready_d;
      rvalid <= rvalid_d;
      rdata <= rdata_d;
      rresp <= rresp_d;
    end
  end

  // ****************************************************************
  // register file and counter
  // ****************************************************************
  udc_ctrl_t ctrl_q, ctrl_d;
  logic [31:0] preset_q, preset_d, nv_q, nv_d, cur_q, cur_d;
  logic [15:0] data_lo_q, data_lo_d, data_hi_q, data_hi_d;
  logic [15:0] cmp_const_q, cmp_const_d, cmp_word_q, cmp_word_d;
  logic dirty_q, dirty_d;
  logic [31:0] preset_val, cur_wval, wr_ctrl;
  logic [15:0] cmp_val;
  logic wr_cur, wr_preset, cmd_confirm, cmd_clear, count_en, load_en;
  logic sel_ok, eq_calc, ge_calc, res_calc, term_calc;
  udc_status_t stat;

  // stored preset is high word over low word
  assign preset_val = ctrl_q.preset_src ? {data_hi_q, data_lo_q}
                                        : preset_q;
  assign cmp_val = ctrl_q.cmp_src ? cmp_word_q : cmp_const_q;
  assign wr_cur = do_write && waddr_q == OFS_CURRENT;
  assign wr_preset = do_write && waddr_q == OFS_PRESET;
  assign cur_wval = wmerge(cur_q, wdat_q, wstb_q);
  assign wr_ctrl = wmerge({16'h0000, ctrl_q}, wdat_q, wstb_q);
  assign cmd_confirm = do_write && waddr_q == OFS_CMD &&
                       wstb_q[0] && wdat_q[CMD_CONFIRM_BIT];
  assign cmd_clear = do_write && waddr_q == OFS_CMD &&
                     wstb_q[0] && wdat_q[CMD_CLEAR_BIT];
  // a falling preset still blocks the scan in which it fell
  assign load_en = scan_q && sync2_q.preset;
  assign count_en = scan_q && sync2_q.pulse && !last_q.pulse &&
                    !sync2_q.preset && !last_q.preset;

  always_comb begin
    ctrl_d = ctrl_q;
    preset_d = preset_q;
    nv_d = nv_q;
    data_lo_d = data_lo_q;
    data_hi_d = data_hi_q;
    cmp_const_d = cmp_const_q;
    cmp_word_d = cmp_word_q;
    dirty_d = dirty_q;
    cur_d = cur_q;
    if (load_en) begin
      cur_d = preset_val;
    end else if (count_en) begin
      cur_d = sync2_q.updown ? cur_q + 32'h0000_0001
                             : cur_q - 32'h0000_0001;
    end
    if (wr_cur) begin
      cur_d = cur_wval;
    end
    if (do_write && waddr_q == OFS_CTRL) begin
      ctrl_d = wr_ctrl[15:0];
      ctrl_d.spare = 3'h0;
    end
    if (do_write && waddr_q == OFS_DATA_LO) begin
      data_lo_d = 16'(wmerge({16'h0000, data_lo_q}, wdat_q, wstb_q));
    end
    if (do_write && waddr_q == OFS_DATA_HI) begin
      data_hi_d = 16'(wmerge({16'h0000, data_hi_q}, wdat_q, wstb_q));
    end
    if (do_write && waddr_q == OFS_CMP_CONST) begin
      cmp_const_d = 16'(wmerge({16'h0000, cmp_const_q}, wdat_q, wstb_q));
    end
    if (do_write && waddr_q == OFS_CMP_WORD) begin
      cmp_word_d = 16'(wmerge({16'h0000, cmp_word_q}, wdat_q, wstb_q));
    end
    if (cmd_confirm) begin
      nv_d = preset_q;
      dirty_d = 1'b0;
    end else if (cmd_clear) begin
      preset_d = nv_q;
      dirty_d = 1'b0;
    end
    if (wr_preset) begin
      preset_d = wmerge(preset_q, wdat_q, wstb_q);
      dirty_d = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= CTRL_RESET;
      preset_q <= PRESET_INIT;
      nv_q <= PRESET_INIT;
      data_lo_q <= WORD_RESET;
      data_hi_q <= WORD_RESET;
      cmp_const_q <= WORD_RESET;
      cmp_word_q <= WORD_RESET;
      dirty_q <= 1'b0;
      // retention means the value rides through reset untouched
      cur_q <= CLEAR_ON_POWERUP ? CUR_ZERO : cur_q;
    end else begin
      ctrl_q <= ctrl_d;
      preset_q <= preset_d;
      nv_q <= nv_d;
      data_lo_q <= data_lo_d;
      data_hi_q <= data_hi_d;
      cmp_const_q <= cmp_const_d;
      cmp_word_q <= cmp_word_d;
      dirty_q <= dirty_d;
      cur_q <= cur_d;
    end
  end

  // ****************************************************************
  // comparators and result outputs
  // ****************************************************************
  assign sel_ok = ctrl_q.cmp_sel == BASE_SLOT ||
                  ctrl_q.cmp_sel == BASE_SLOT + 8'h01;
  // only the value is compared, never the zero flag
  assign eq_calc = sel_ok && cur_d == {16'h0000, cmp_val};
  assign ge_calc = sel_ok && cur_d >= {16'h0000, cmp_val};
  assign res_calc = ctrl_q.term_ge ? ge_calc : eq_calc;

  always_comb begin
    unique case (ctrl_q.term_mode)
      UDC_TERM_AND: term_calc = res_calc && sync2_q.cond;
      UDC_TERM_OR: term_calc = res_calc || sync2_q.cond;
      default: term_calc = res_calc;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      counter_zero <= 1'b0;
      equal_out <= 1'b0;
      at_least_out <= 1'b0;
      term_out <= 1'b0;
    end else if (scan_q) begin
      counter_zero <= cur_d == CUR_ZERO;
      equal_out <= eq_calc;
      at_least_out <= ge_calc;
      term_out <= term_calc;
    end
  end

  assign stat = '{dirty: dirty_q, term: term_out, ge: at_least_out,
                  eq: equal_out, zero: counter_zero};

  always_comb begin
    unique case (araddr)
      OFS_CTRL: rd_mux = {16'h0000, ctrl_q};
      OFS_PRESET: rd_mux = preset_q;
      OFS_DATA_LO: rd_mux = {16'h0000, data_lo_q};
      OFS_DATA_HI: rd_mux = {16'h0000, data_hi_q};
      OFS_CURRENT: rd_mux = cur_q;
      OFS_NV_PRESET: rd_mux = nv_q;
      OFS_CMP_CONST: rd_mux = {16'h0000, cmp_const_q};
      OFS_CMP_WORD: rd_mux = {16'h0000, cmp_word_q};
      OFS_STATUS: rd_mux = {27'h0000000, stat};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  zero_flag_a: assert property (scan_q
    |=> counter_zero == (cur_q == CUR_ZERO))
    else $error("zero flag disagrees with current value");
  preset_load_a: assert property (load_en && !wr_cur
    |=> cur_q == $past(preset_val))
    else $error("preset not loaded");
  preset_block_a: assert property (scan_q && (sync2_q.preset || last_q.preset)
    && !wr_cur && !sync2_q.preset |=> $stable(cur_q))
    else $error("count during preset");
  count_up_a: assert property (count_en && sync2_q.updown && !wr_cur
    |=> cur_q == $past(cur_q) + 32'h0000_0001)
    else $error("up count wrong");
  wrap_down_a: assert property (count_en && !sync2_q.updown && !wr_cur
    && cur_q == CUR_ZERO |=> cur_q == CUR_MAX)
    else $error("down wrap wrong");
  wrap_up_a: assert property (count_en && sync2_q.updown && !wr_cur
    && cur_q == CUR_MAX |=> cur_q == CUR_ZERO)
    else $error("up wrap wrong");
  edge_only_a: assert property (scan_q && !load_en && !wr_cur
    && !(sync2_q.pulse && !last_q.pulse) |=> $stable(cur_q))
    else $error("count without rising edge");
  sw_write_a: assert property (wr_cur |=> cur_q == $past(cur_wval))
    else $error("current write not applied");
  nv_keep_a: assert property (!cmd_confirm |=> $stable(nv_q))
    else $error("non-volatile copy changed");
  confirm_a: assert property (cmd_confirm |=> nv_q == $past(preset_q))
    else $error("confirm did not copy");
  clear_a: assert property (cmd_clear && !wr_preset && !cmd_confirm
    |=> preset_q == $past(nv_q))
    else $error("clear did not restore");
  equal_res_a: assert property (scan_q |=> equal_out == $past(eq_calc)
    && at_least_out == $past(ge_calc))
    else $error("compare result wrong");
  res_hold_a: assert property (!scan_q |=> $stable(equal_out)
    && $stable(term_out))
    else $error("result moved between scans");

  load_c: cover property (load_en ##[1:300] count_en);
  wrap_c: cover property (count_en && cur_q == CUR_MAX && sync2_q.updown);
  confirm_c: cover property (wr_preset ##[1:50] cmd_confirm);
  equal_c: cover property (equal_out && term_out);

endmodule

// ==== include/udc_pkg.sv ====
// constants, field layouts and carrier types of the up/down counter block
// assumes a 32-bit axi4-lite register bus and a 100 MHz system clock
package udc_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned SCAN_TIME_NS = 1000;
  localparam int unsigned SCAN_CYCLES =
    (SCAN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************************************
  // register byte offsets
  // ****************************************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PRESET = 8'h04;
  localparam logic [7:0] OFS_DATA_LO = 8'h08;
  localparam logic [7:0] OFS_DATA_HI = 8'h0C;
  localparam logic [7:0] OFS_CURRENT = 8'h10;
  localparam logic [7:0] OFS_NV_PRESET = 8'h14;
  localparam logic [7:0] OFS_CMD = 8'h18;
  localparam logic [7:0] OFS_CMP_CONST = 8'h1C;
  localparam logic [7:0] OFS_CMP_WORD = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;

  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int unsigned CMD_CONFIRM_BIT = 0;
  localparam int unsigned CMD_CLEAR_BIT = 1;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [31:0] PRESET_INIT = 32'h0000_0000;
  localparam logic [31:0] CUR_ZERO = 32'h0000_0000;
  localparam logic [31:0] CUR_MAX = 32'hFFFF_FFFF;
  localparam logic [7:0] MAX_BASE_SLOT = 8'hFE;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    UDC_TERM_PLAIN = 2'h0,
    UDC_TERM_AND = 2'h1,
    UDC_TERM_OR = 2'h2,
    UDC_TERM_HOLD = 2'h3
  } udc_term_t;

  typedef struct packed {
    logic [7:0] cmp_sel;
    logic [2:0] spare;
    logic term_ge;
    udc_term_t term_mode;
    logic cmp_src;
    logic preset_src;
  } udc_ctrl_t;

  typedef struct packed {
    logic preset;
    logic pulse;
    logic updown;
    logic cond;
  } udc_ladder_t;

  typedef struct packed {
    logic dirty;
    logic term;
    logic ge;
    logic eq;
    logic zero;
  } udc_status_t;

endpackage

// ==== dv/udc_top_bench.sv ====
// self-checking bench for the up/down counter block with comparators
// assumes udc_pkg is compiled first; bench drives bus and ladder pins
`timescale 1ns/1ns
module udc_top_bench
  import udc_pkg::*;
;
  // ****************************************************************
  // settings and signals
  // ****************************************************************
  // short scan keeps the run small; all scan waits derive from it
  localparam int SCAN = 4;
  localparam logic [7:0] BASE = 8'h04;
  localparam int TMO = 64;
  logic aclk;
  logic aresetn;
  logic [7:0] awaddr;
  logic awvalid;
  logic awready;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic wvalid;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready;
  logic [7:0] araddr;
  logic arvalid;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready;
  udc_ladder_t ladder_in;
  logic counter_zero;
  logic equal_out;
  logic at_least_out;
  logic term_out;
  int failures = 0;
  int cmp_count = 0;

  udc_top #(.SCAN_DIV(SCAN), .BASE_SLOT(BASE), .CLEAR_ON_POWERUP(1'b0))
  i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .ladder_in(ladder_in), .counter_zero(counter_zero),
    .equal_out(equal_out), .at_least_out(at_least_out),
    .term_out(term_out));

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic finish_test();
    $display("checks %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    int n;
    logic ha, hw, hb;
    n = 0;
    hb = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!hb) begin
      @(negedge aclk);
      n++;
      ha = awvalid && awready;
      hw = wvalid && wready;
      hb = bvalid && bready;
      if (hb) chk($sformatf("bresp %h", a), {30'h0, bresp}, {30'h0, er});
      if (n > TMO) begin
        failures++;
        finish_test();
      end
      @(posedge aclk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
      if (hb) bready <= 1'b0;
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int n;
    logic ha, hr;
    n = 0;
    hr = 1'b0;
    d = 32'h0;
    r = 2'h0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!hr) begin
      @(negedge aclk);
      n++;
      ha = arvalid && arready;
      hr = rvalid && rready;
      d = rdata;
      r = rresp;
      if (n > TMO) begin
        failures++;
        finish_test();
      end
      @(posedge aclk);
      if (ha) arvalid <= 1'b0;
      if (hr) rready <= 1'b0;
    end
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk($sformatf("rdata %h", a), d, e);
    chk($sformatf("rresp %h", a), {30'h0, r}, {30'h0, er});
  endtask

  // hold long enough for sync plus k full scans
  task automatic scans(input int k);
    repeat (k * SCAN + 3) @(posedge aclk);
  endtask

  task automatic pulse_once();
    ladder_in.pulse <= 1'b0;
    scans(1);
    ladder_in.pulse <= 1'b1;
    scans(1);
  endtask

  // order: zero, equal, at least, term
  task automatic outs(input logic [3:0] e);
    @(negedge aclk);
    chk("outputs", {28'h0, counter_zero, equal_out, at_least_out,
        term_out}, {28'h0, e});
    @(posedge aclk);
  endtask

  function automatic logic term_exp(input logic r, input int m,
                                    input logic c);
    if (m == 1) return r & c;
    if (m == 2) return r | c;
    return r;
  endfunction

  // ****************************************************************
  // clock, watchdog, sequence
  // ****************************************************************
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  initial begin
    repeat (100000) @(posedge aclk);
    failures++;
    finish_test();
  end

  initial begin
    logic hit;
    aresetn = 1'b0;
    awaddr = 8'h00;
    awvalid = 1'b0;
    wdata = 32'h0;
    wstrb = 4'hF;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 8'h00;
    arvalid = 1'b0;
    rready = 1'b0;
    // preset held from the start so the first scan defines the count
    ladder_in = 4'b1000;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    // preset load, pulses ignored meanwhile
    wr(OFS_CTRL, 32'h0, RESP_OKAY);
    wr(OFS_PRESET, 32'hFFFF_FFFE, RESP_OKAY);
    ladder_in.preset <= 1'b1;
    ladder_in.updown <= 1'b1;
    scans(2);
    rc(OFS_CURRENT, 32'hFFFF_FFFE, RESP_OKAY);
    pulse_once();
    pulse_once();
    rc(OFS_CURRENT, 32'hFFFF_FFFE, RESP_OKAY);
    // edge in the very scan that preset falls must not count
    ladder_in.pulse <= 1'b0;
    scans(1);
    ladder_in.preset <= 1'b0;
    ladder_in.pulse <= 1'b1;
    scans(2);
    rc(OFS_CURRENT, 32'hFFFF_FFFE, RESP_OKAY);
    pulse_once();
    rc(OFS_CURRENT, 32'hFFFF_FFFF, RESP_OKAY);
    outs(4'b0000);
    pulse_once();
    rc(OFS_CURRENT, 32'h0, RESP_OKAY);
    outs(4'b1000);
    ladder_in.updown <= 1'b0;
    pulse_once();
    rc(OFS_CURRENT, 32'hFFFF_FFFF, RESP_OKAY);
    outs(4'b0000);
    // comparators on the counter's base slot
    wr(OFS_CTRL, {16'h0, BASE, 8'h00}, RESP_OKAY);
    wr(OFS_CMP_CONST, 32'h5, RESP_OKAY);
    wr(OFS_CURRENT, 32'h5, RESP_OKAY);
    rc(OFS_CURRENT, 32'h5, RESP_OKAY);
    scans(1);
    outs(4'b0111);
    pulse_once();
    outs(4'b0000);
    ladder_in.updown <= 1'b1;
    pulse_once();
    pulse_once();
    outs(4'b0010);
    // every term mode, compare result off and on
    for (int cv = 5; cv <= 7; cv += 2) begin
      wr(OFS_CMP_CONST, 32'(cv), RESP_OKAY);
      for (int m = 0; m < 4; m++) begin
        wr(OFS_CTRL, {16'h0, BASE, 3'h0, 1'b1, 2'(m), 2'h0}, RESP_OKAY);
        for (int ci = 0; ci < 2; ci++) begin
          ladder_in.cond <= 1'(ci);
          scans(1);
          outs({2'b00, cv == 5, term_exp(cv == 5, m, 1'(ci))});
        end
      end
    end
    // stored compare word uses only its low 16 bits
    wr(OFS_CMP_WORD, 32'hABCD_0006, RESP_OKAY);
    for (int s = 3; s < 7; s++) begin
      wr(OFS_CTRL, {16'h0, 8'(s), 8'h02}, RESP_OKAY);
      scans(1);
      hit = (8'(s) == BASE) || (8'(s) == BASE + 8'h01);
      outs({1'b0, hit, hit, hit});
    end
    // preset from two data words
    wr(OFS_CTRL, 32'h1, RESP_OKAY);
    wr(OFS_DATA_LO, 32'h5678, RESP_OKAY);
    wr(OFS_DATA_HI, 32'h1234, RESP_OKAY);
    ladder_in.preset <= 1'b1;
    scans(2);
    rc(OFS_CURRENT, 32'h1234_5678, RESP_OKAY);
    ladder_in.preset <= 1'b0;
    // working copy, confirm and clear
    wr(OFS_PRESET, 32'hA5A5_0001, RESP_OKAY);
    rc(OFS_NV_PRESET, 32'h0, RESP_OKAY);
    wr(OFS_CMD, 32'h1, RESP_OKAY);
    rc(OFS_NV_PRESET, 32'hA5A5_0001, RESP_OKAY);
    wr(OFS_PRESET, 32'h33, RESP_OKAY);
    wr(OFS_CMD, 32'h2, RESP_OKAY);
    rc(OFS_PRESET, 32'hA5A5_0001, RESP_OKAY);
    // refused places
    wr(OFS_NV_PRESET, 32'h77, RESP_OKAY);
    rc(OFS_NV_PRESET, 32'hA5A5_0001, RESP_OKAY);
    wr(8'h30, 32'h1, RESP_SLVERR);
    rc(8'h30, 32'h0, RESP_SLVERR);
    // second reset: count survives, other registers clear
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rc(OFS_CURRENT, 32'h1234_5678, RESP_OKAY);
    rc(OFS_PRESET, PRESET_INIT, RESP_OKAY);
    rc(OFS_CTRL, 32'h0, RESP_OKAY);
    finish_test();
  end
endmodule
